// [hdl/fcm_clock_source_unit.sv]
// clock source unit: fll, reference selection, clock muxing and gating
// assumes ext_ref_in is a slow level sampled on clk_sys, clocks are
// produced as flip-flop levels derived from enable ticks of clk_sys
`timescale 1ns/100ps
module fcm_clock_source_unit
	import fcm_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic debug_active,
	input wire logic stop_req,
	input wire logic ext_ref_in,
	input wire logic [7:0] factory_trim,
	input wire logic factory_fine_trim_bit,
	output logic main_output_clock,
	output logic debug_local_clock,
	output logic fixed_frequency_clock,
	output logic fixed_frequency_valid,
	output logic internal_ref_out_clock,
	output logic external_ref_out_clock,
	output logic fll_locked,
	output fcm_mode_t mode
);
	logic [1:0] clock_select_reg;
	logic [2:0] reference_divider_reg;
	logic reference_select_reg;
	logic internal_ref_out_enable_reg;
	logic internal_ref_stop_enable_reg;
	logic [1:0] bus_divider_reg;
	logic low_power_bit_reg;
	logic external_ref_out_enable_reg;
	logic external_ref_stop_enable_reg;
	logic [7:0] trim_register_reg;
	logic fine_trim_bit_reg;
	logic [1:0] dco_range_select_reg;
	logic max_freq_crystal_option_reg;
	logic trim_load_reg;
	logic [1:0] clock_select_status_reg;
	logic reference_select_status_reg;
	logic [1:0] dco_range_status_reg;
	logic [1:0] cs_meta_reg, cs_sync_reg;
	logic ref_meta_reg, ref_sync_reg;
	logic [1:0] drs_meta_reg, drs_sync_reg;
	logic ext_meta_reg, ext_sync_reg, ext_prev_reg;
	logic [11:0] ext_idle_reg;
	logic [6:0] reference_divider_cnt_reg;
	logic [9:0] reference_select_alias_cnt_reg;
	logic reference_select_alias_level_reg;
	logic [15:0] dco_acc_reg, dco_step_reg;
	logic [10:0] dco_cnt_reg;
	logic [2:0] lock_cnt_reg;
	logic [9:0] start_cnt_reg;
	logic [2:0] div_cnt_reg;
	logic [1:0] lr_cnt_reg;
	logic [2:0] ff_cnt_reg;
	logic [7:0] rdata_next;
	logic ext_edge, ext_alive, ext_div_tick, reference_select_alias_tick, reference_select_alias_run;
	logic fll_ref_tick, fll_on, dco_tick, src_tick, stopped, lp_bypass;
	logic range_busy;
	logic [16:0] dco_sum;
	logic [10:0] target;
	logic signed [16:0] err;
	logic signed [17:0] step_adj;

	// decoded state conditions
	assign stopped = stop_req;
	assign lp_bypass = low_power_bit_reg && !debug_active &&
		clock_select_status_reg != CS_FLL;
	assign fll_on = !lp_bypass && !stopped;
	assign range_busy = start_cnt_reg != '0;

	// register writes; trim load takes precedence on its single cycle
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			clock_select_reg <= CS_RESET;
			reference_divider_reg <= REFERENCE_DIVIDER_RESET;
			reference_select_reg <= REFSEL_RESET;
			internal_ref_out_enable_reg <= 1'b0;
			internal_ref_stop_enable_reg <= 1'b0;
			bus_divider_reg <= BUS_DIVIDER_RESET;
			low_power_bit_reg <= 1'b0;
			external_ref_out_enable_reg <= 1'b0;
			external_ref_stop_enable_reg <= 1'b0;
			dco_range_select_reg <= DRS_RESET;
			max_freq_crystal_option_reg <= 1'b0;
		end else if (reg_wr) begin
			if (reg_addr == ADDR_CTRL1) begin
				clock_select_reg <= reg_wdata[CS_POS+:2];
				reference_divider_reg <= reg_wdata[REFERENCE_DIVIDER_POS+:3];
				reference_select_reg <= reg_wdata[REFSEL_POS];
				internal_ref_out_enable_reg <= reg_wdata[IREN_POS];
				internal_ref_stop_enable_reg <= reg_wdata[IRSTEN_POS];
			end else if (reg_addr == ADDR_CTRL2) begin
				bus_divider_reg <= reg_wdata[BUS_DIVIDER_POS+:2];
				low_power_bit_reg <= reg_wdata[LP_POS];
				external_ref_out_enable_reg <= reg_wdata[EREN_POS];
				external_ref_stop_enable_reg <= reg_wdata[ERSTEN_POS];
			end else if (reg_addr == ADDR_STAT) begin
				max_freq_crystal_option_reg <= reg_wdata[DMX_POS];
				if (!low_power_bit_reg &&
					reg_wdata[DRS_POS+:2] != RANGE_RSVD) begin
					dco_range_select_reg <= reg_wdata[DRS_POS+:2];
				end
			end
		end
	end

	// trim: reset loads the debug values and arms the load, the port is sampled after release
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			trim_load_reg <= 1'b1;
			trim_register_reg <= TRIM_DEBUG;
			fine_trim_bit_reg <= FINE_TRIM_BIT_DEBUG;
		end else if (trim_load_reg) begin
			trim_load_reg <= 1'b0;
			trim_register_reg <= debug_active ? TRIM_DEBUG : factory_trim;
			fine_trim_bit_reg <= debug_active ? FINE_TRIM_BIT_DEBUG : factory_fine_trim_bit;
		end else if (reg_wr && reg_addr == ADDR_TRIM) begin
			trim_register_reg <= reg_wdata;
		end else if (reg_wr && reg_addr == ADDR_STAT) begin
			fine_trim_bit_reg <= reg_wdata[FINE_TRIM_BIT_POS];
		end
	end

	// read mux, data valid the cycle after the strobe
	always_comb begin
		rdata_next = 8'h00;
		if (reg_addr == ADDR_CTRL1) begin
			rdata_next = {clock_select_reg, reference_divider_reg,
				reference_select_reg, internal_ref_out_enable_reg,
				internal_ref_stop_enable_reg};
		end else if (reg_addr == ADDR_CTRL2) begin
			rdata_next = {bus_divider_reg, 2'h0, low_power_bit_reg,
				external_ref_out_enable_reg, 1'b0,
				external_ref_stop_enable_reg};
		end else if (reg_addr == ADDR_TRIM) begin
			rdata_next = trim_register_reg;
		end else begin
			rdata_next = {dco_range_status_reg, max_freq_crystal_option_reg,
				reference_select_status_reg, clock_select_status_reg,
				fll_locked, fine_trim_bit_reg};
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_next;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cs_meta_reg <= CS_RESET;
			cs_sync_reg <= CS_RESET;
			ref_meta_reg <= REFSEL_RESET;
			ref_sync_reg <= REFSEL_RESET;
			drs_meta_reg <= DRS_RESET;
			drs_sync_reg <= DRS_RESET;
		end else begin
			cs_meta_reg <= clock_select_reg;
			cs_sync_reg <= cs_meta_reg;
			ref_meta_reg <= reference_select_reg;
			ref_sync_reg <= ref_meta_reg;
			drs_meta_reg <= dco_range_select_reg;
			drs_sync_reg <= drs_meta_reg;
		end
	end

	// external reference: sync, edge detect and loss watchdog
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ext_meta_reg <= 1'b0;
			ext_sync_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
			ext_idle_reg <= 12'(EXT_LOST_CYC);
		end else begin
			ext_meta_reg <= ext_ref_in;
			ext_sync_reg <= ext_meta_reg;
			ext_prev_reg <= ext_sync_reg;
			if (ext_edge) begin
				ext_idle_reg <= '0;
			end else if (ext_alive) begin
				ext_idle_reg <= ext_idle_reg + 12'h001;
			end
		end
	end
	assign ext_edge = ext_sync_reg && !ext_prev_reg;
	assign ext_alive = ext_idle_reg < 12'(EXT_LOST_CYC);

	// reference divider by power of two
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			reference_divider_cnt_reg <= '0;
		end else if (ext_div_tick) begin
			reference_divider_cnt_reg <= '0;
		end else if (ext_edge) begin
			reference_divider_cnt_reg <= reference_divider_cnt_reg + 7'h01;
		end
	end
	assign ext_div_tick = ext_edge &&
		reference_divider_cnt_reg == 7'((8'h01 << reference_divider_reg) - 8'h01);

	// trimmed internal oscillator
	// larger trim gives a longer half period
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			reference_select_alias_cnt_reg <= '0;
			reference_select_alias_level_reg <= 1'b0;
		end else if (reference_select_alias_run) begin
			if (reference_select_alias_cnt_reg >= 10'(REFERENCE_SELECT_ALIAS_BASE_HALF_CYC) +
				{1'b0, trim_register_reg, fine_trim_bit_reg}) begin
				reference_select_alias_cnt_reg <= '0;
				reference_select_alias_level_reg <= !reference_select_alias_level_reg;
			end else begin
				reference_select_alias_cnt_reg <= reference_select_alias_cnt_reg + 10'h001;
			end
		end
	end
	assign reference_select_alias_run = !stopped ||
		(internal_ref_out_enable_reg && internal_ref_stop_enable_reg);
	assign reference_select_alias_tick = reference_select_alias_run && !reference_select_alias_level_reg &&
		reference_select_alias_cnt_reg >= 10'(REFERENCE_SELECT_ALIAS_BASE_HALF_CYC) +
		{1'b0, trim_register_reg, fine_trim_bit_reg};

	assign fll_ref_tick = reference_select_status_reg ? reference_select_alias_tick
		: ext_div_tick;

	always_comb begin
		target = 11'(FACTOR_LOW >> FACTOR_SHIFT);
		case (dco_range_status_reg)
			RANGE_MID: target = max_freq_crystal_option_reg ?
				11'(FACTOR_X_MID >> FACTOR_SHIFT) :
				11'(FACTOR_MID >> FACTOR_SHIFT);
			RANGE_HIGH: target = max_freq_crystal_option_reg ?
				11'(FACTOR_X_HIGH >> FACTOR_SHIFT) :
				11'(FACTOR_HIGH >> FACTOR_SHIFT);
			default: target = max_freq_crystal_option_reg ?
				11'(FACTOR_X_LOW >> FACTOR_SHIFT) :
				11'(FACTOR_LOW >> FACTOR_SHIFT);
		endcase
	end

	// dco phase accumulator, carry is one dco tick
	assign dco_sum = {1'b0, dco_acc_reg} + {1'b0, dco_step_reg};
	assign dco_tick = fll_on && !range_busy ? dco_sum[16] : 1'b0;
	assign err = 17'(signed'({6'h00, target})) -
		17'(signed'({6'h00, dco_cnt_reg}));
	assign step_adj = 18'(signed'({2'b00, dco_step_reg})) +
		18'(err <<< LOOP_GAIN_SHIFT);

	// frequency loop
	// the count over one reference period is steered to a quarter of the factor (FACTOR_SHIFT)
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			dco_acc_reg <= '0;
			dco_step_reg <= STEP_RESET;
			dco_cnt_reg <= '0;
			lock_cnt_reg <= '0;
		end else if (!fll_on) begin
			lock_cnt_reg <= '0;
			dco_cnt_reg <= '0;
		end else if (ref_sync_reg != reference_select_status_reg &&
			clock_select_status_reg == CS_FLL &&
			(ref_sync_reg || ext_alive)) begin
			lock_cnt_reg <= '0;
			dco_cnt_reg <= '0;
		end else if (range_busy) begin
			lock_cnt_reg <= '0;
			dco_cnt_reg <= '0;
		end else begin
			dco_acc_reg <= dco_sum[15:0];
			if (fll_ref_tick) begin
				dco_cnt_reg <= '0;
				if (step_adj < 18'sd1) begin
					dco_step_reg <= 16'h0001;
				end else if (step_adj > 18'sd65535) begin
					dco_step_reg <= 16'hffff;
				end else begin
					dco_step_reg <= step_adj[15:0];
				end
				if (err > 17'sd2 || err < -17'sd2) begin
					lock_cnt_reg <= '0;
				end else if (lock_cnt_reg != 3'(LOCK_REFS)) begin
					lock_cnt_reg <= lock_cnt_reg + 3'h1;
				end
			end else if (dco_tick && dco_cnt_reg != '1) begin
				dco_cnt_reg <= dco_cnt_reg + 11'h001;
			end
		end
	end
	assign fll_locked = lock_cnt_reg == 3'(LOCK_REFS);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			clock_select_status_reg <= CS_RESET;
			reference_select_status_reg <= REFSEL_RESET;
			dco_range_status_reg <= DRS_RESET;
			start_cnt_reg <= '0;
		end else begin
			if (cs_sync_reg == CS_INT ||
				(cs_sync_reg == CS_EXT && ext_alive) ||
				(cs_sync_reg == CS_FLL && !range_busy &&
				!stopped)) begin
				clock_select_status_reg <= cs_sync_reg;
			end
			if (ref_sync_reg || ext_alive) begin
				reference_select_status_reg <= ref_sync_reg;
			end
			if (drs_sync_reg != dco_range_status_reg && !range_busy) begin
				start_cnt_reg <= 10'(DCO_START_CYC);
			end else if (start_cnt_reg == 10'h001) begin
				dco_range_status_reg <= drs_sync_reg;
				start_cnt_reg <= '0;
			end else if (range_busy) begin
				start_cnt_reg <= start_cnt_reg - 10'h001;
			end
		end
	end

	always_comb begin
		case (clock_select_status_reg)
			CS_INT: src_tick = reference_select_alias_tick;
			CS_EXT: src_tick = ext_edge;
			default: src_tick = dco_tick;
		endcase
	end

	// divider uses live field
	// compare is against the current field, so a rewrite acts at once
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			div_cnt_reg <= '0;
			main_output_clock <= 1'b0;
		end else if (!stopped && src_tick) begin
			if (div_cnt_reg >= 3'((4'h1 << bus_divider_reg) - 4'h1)) begin
				div_cnt_reg <= '0;
				main_output_clock <= !main_output_clock;
			end else begin
				div_cnt_reg <= div_cnt_reg + 3'h1;
			end
		end
	end

	// low range dco halved
	// the range ratio divides back down to the low range rate
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			lr_cnt_reg <= '0;
			debug_local_clock <= 1'b0;
		end else if (dco_tick && !lp_bypass) begin
			if (lr_cnt_reg >= dco_range_status_reg) begin
				lr_cnt_reg <= '0;
				debug_local_clock <= !debug_local_clock;
			end else begin
				lr_cnt_reg <= lr_cnt_reg + 2'h1;
			end
		end
	end

	// fixed clock and validity
	// valid once main toggles at least four times per half period
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			fixed_frequency_clock <= 1'b0;
			fixed_frequency_valid <= 1'b0;
			ff_cnt_reg <= '0;
		end else if (!stopped) begin
			if (fll_ref_tick) begin
				fixed_frequency_clock <= !fixed_frequency_clock;
				fixed_frequency_valid <= ff_cnt_reg >= 3'(FF_MIN_TOGGLES);
				ff_cnt_reg <= '0;
			end else if (src_tick && div_cnt_reg == '0 &&
				ff_cnt_reg != '1) begin
				ff_cnt_reg <= ff_cnt_reg + 3'h1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			internal_ref_out_clock <= 1'b0;
			external_ref_out_clock <= 1'b0;
		end else begin
			if (internal_ref_out_enable_reg &&
				(!stopped || internal_ref_stop_enable_reg)) begin
				internal_ref_out_clock <= reference_select_alias_level_reg;
			end
			if (external_ref_out_enable_reg &&
				(!stopped || external_ref_stop_enable_reg)) begin
				external_ref_out_clock <= ext_sync_reg;
			end
		end
	end

	// current operating state from the status fields
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mode <= FCM_ENGAGED_INT;
		end else if (stopped) begin
			mode <= FCM_STOP;
		end else begin
			case (clock_select_status_reg)
				CS_INT: mode <= lp_bypass ? FCM_BYPASS_INT_LP
					: FCM_BYPASS_INT;
				CS_EXT: mode <= lp_bypass ? FCM_BYPASS_EXT_LP
					: FCM_BYPASS_EXT;
				default: mode <= reference_select_status_reg ?
					FCM_ENGAGED_INT : FCM_ENGAGED_EXT;
			endcase
		end
	end
endmodule : fcm_clock_source_unit

// [hdl/fcm_pkg.sv]
// constants, register map and mode types of the clock source unit
// assumes a 25 MHz system clock and 8-bit registers on a plain port
// Behaviour
// - clock select 00, ref 1: engaged internal
// - clock select 00, ref 0: engaged external
// - 01, ref 1, debug or no lp: bypass
// - 01, ref 1, lp: internal, fll off
// - 10, ref 0, debug or no lp: bypass
// - 10, ref 0, lp: external, fll off
// - stop holds clocks except enabled references
// - reference status follows, absent external keeps old; engaged switch relocks fll
// - clock status follows; unavailable source keeps old
// - range writes ignored while low power set
// - range change waits dco start, relocks
// - bus divider acts immediately
// - crystal option picks alternate multipliers
// - fll locks to factor times reference
// - internal reference output when enabled
// - larger trim lengthens internal reference period
// - reset loads factory trim and fine trim, debug values while debug active
// - external reference output when enabled
// - fixed clock is fll reference halved, validity flagged
// - debug clock is low range dco halved
// - range codes and factor table
package fcm_pkg;
	// register addresses
	localparam logic [1:0] ADDR_CTRL1 = 2'h0;
	localparam logic [1:0] ADDR_CTRL2 = 2'h1;
	localparam logic [1:0] ADDR_TRIM = 2'h2;
	localparam logic [1:0] ADDR_STAT = 2'h3;
	// ctrl1 fields
	localparam int CS_POS = 6;
	localparam int REFERENCE_DIVIDER_POS = 3;
	localparam int REFSEL_POS = 2;
	localparam int IREN_POS = 1;
	localparam int IRSTEN_POS = 0;
	// ctrl2 fields
	localparam int BUS_DIVIDER_POS = 6;
	localparam int LP_POS = 3;
	localparam int EREN_POS = 2;
	localparam int ERSTEN_POS = 0;
	// status and control fields
	localparam int DRS_POS = 6;
	localparam int DMX_POS = 5;
	localparam int REFST_POS = 4;
	localparam int CSST_POS = 2;
	localparam int LOCK_POS = 1;
	localparam int FINE_TRIM_BIT_POS = 0;
	// reset values
	localparam logic [1:0] CS_RESET = 2'h0;
	localparam logic REFSEL_RESET = 1'b1;
	localparam logic [2:0] REFERENCE_DIVIDER_RESET = 3'h0;
	localparam logic [1:0] BUS_DIVIDER_RESET = 2'h1;
	localparam logic [1:0] DRS_RESET = 2'h0;
	localparam logic [7:0] TRIM_DEBUG = 8'h80;
	localparam logic FINE_TRIM_BIT_DEBUG = 1'b0;
	localparam logic [15:0] STEP_RESET = 16'h4000;
	// range and clock select codes
	localparam logic [1:0] RANGE_LOW = 2'h0;
	localparam logic [1:0] RANGE_MID = 2'h1;
	localparam logic [1:0] RANGE_HIGH = 2'h2;
	localparam logic [1:0] RANGE_RSVD = 2'h3;
	localparam logic [1:0] CS_FLL = 2'h0;
	localparam logic [1:0] CS_INT = 2'h1;
	localparam logic [1:0] CS_EXT = 2'h2;
	// fll factors, default and crystal tuned
	localparam int FACTOR_LOW = 512;
	localparam int FACTOR_MID = 1024;
	localparam int FACTOR_HIGH = 1536;
	localparam int FACTOR_X_LOW = 608;
	localparam int FACTOR_X_MID = 1216;
	localparam int FACTOR_X_HIGH = 1824;
	// dco is modelled at a quarter rate to fit under clk_sys
	localparam int FACTOR_SHIFT = 2;
	// timing
	localparam int CLK_KHZ = 25000;
	localparam int DCO_START_NS = 20000;
	localparam int DCO_START_CYC = (DCO_START_NS * CLK_KHZ + 999999) / 1000000;
	localparam int EXT_LOST_NS = 64000;
	localparam int EXT_LOST_CYC = (EXT_LOST_NS * CLK_KHZ + 999999) / 1000000;
	localparam int REFERENCE_SELECT_ALIAS_BASE_HALF_CYC = 250;
	localparam int LOCK_REFS = 4;
	localparam int LOCK_TOL = 2;
	localparam int LOOP_GAIN_SHIFT = 5;
	localparam int FF_MIN_TOGGLES = 4;
	// operating states
	typedef enum logic [2:0] {
		FCM_ENGAGED_INT,
		FCM_ENGAGED_EXT,
		FCM_BYPASS_INT,
		FCM_BYPASS_INT_LP,
		FCM_BYPASS_EXT,
		FCM_BYPASS_EXT_LP,
		FCM_STOP
	} fcm_mode_t;
endpackage : fcm_pkg

// [verif/fcm_clock_source_unit_chk.sv]
// port-level assertions for the clock source unit
// assumes a bind onto fcm_clock_source_unit and the single clk_sys domain
`timescale 1ns/100ps
module fcm_clock_source_unit_chk
	import fcm_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic debug_active,
	input wire logic main_output_clock,
	input wire logic debug_local_clock,
	input wire logic fixed_frequency_clock,
	input wire logic internal_ref_out_clock,
	input wire logic external_ref_out_clock,
	input wire logic fll_locked,
	input fcm_mode_t mode
);
	logic [7:0] ctrl1_reg;
	logic [7:0] ctrl2_reg;
	logic reference_select_alias_run;
	logic eref_run;
	// shadow of the enable bits, rebuilt from bus writes only
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ctrl1_reg <= 8'h04;
			ctrl2_reg <= 8'h40;
		end else if (reg_wr && reg_addr == ADDR_CTRL1) begin
			ctrl1_reg <= reg_wdata;
		end else if (reg_wr && reg_addr == ADDR_CTRL2) begin
			ctrl2_reg <= reg_wdata;
		end
	end
	// references that may keep running in stop
	assign reference_select_alias_run = ctrl1_reg[IREN_POS] & ctrl1_reg[IRSTEN_POS];
	assign eref_run = ctrl2_reg[EREN_POS] & ctrl2_reg[ERSTEN_POS];
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// repeats leave room for the output register lag
	stop_static_a: assert property (
		(mode == FCM_STOP) [*2] |-> $stable(main_output_clock) &&
		$stable(debug_local_clock) && $stable(fixed_frequency_clock))
		else $error("generated clock moved in stop");
	stop_reference_select_alias_a: assert property (
		(mode == FCM_STOP && !reference_select_alias_run) [*4] |->
		$stable(internal_ref_out_clock))
		else $error("internal reference ran in stop");
	stop_eref_a: assert property (
		(mode == FCM_STOP && !eref_run) [*4] |->
		$stable(external_ref_out_clock))
		else $error("external reference ran in stop");
	reference_select_alias_off_a: assert property (
		(!ctrl1_reg[IREN_POS]) [*4] |-> $stable(internal_ref_out_clock))
		else $error("internal reference out while disabled");
	eref_off_a: assert property (
		(!ctrl2_reg[EREN_POS]) [*4] |-> $stable(external_ref_out_clock))
		else $error("external reference out while disabled");
	dbg_lp_int_a: assert property (
		(mode == FCM_BYPASS_INT_LP) [*4] |-> $stable(debug_local_clock))
		else $error("debug clock in internal low power");
	dbg_lp_ext_a: assert property (
		(mode == FCM_BYPASS_EXT_LP) [*4] |-> $stable(debug_local_clock))
		else $error("debug clock in external low power");
	fll_off_int_a: assert property (
		(mode == FCM_BYPASS_INT_LP) [*4] |-> !fll_locked)
		else $error("fll locked in internal low power");
	fll_off_ext_a: assert property (
		(mode == FCM_BYPASS_EXT_LP) [*4] |-> !fll_locked)
		else $error("fll locked in external low power");
	mode_debug_a: assert property (
		debug_active [*6] |->
		!(mode inside {FCM_BYPASS_INT_LP, FCM_BYPASS_EXT_LP}))
		else $error("low power state while debug active");
endmodule : fcm_clock_source_unit_chk

// [verif/fcm_xtal_model.sv]
// crystal oscillator stand-in on the external reference pin
// assumes the bench starts and stops it through run
`timescale 1ns/100ps
module fcm_xtal_model #(
	parameter int HALF_NS = 500
) (
	input wire logic run,
	output logic ref_out
);
	// reference in range
	// 1 MHz default sits well inside the accepted span
	// 5 ns offset keeps every swing off the rising clk_sys edge
	initial begin
		ref_out = 1'b0;
		#5;
		forever begin
			#(HALF_NS);
			// a stopped crystal rests low rather than freezing mid-swing
			ref_out = run ? ~ref_out : 1'b0;
		end
	end
endmodule : fcm_xtal_model

// [verif/fcm_clock_source_unit_tb.sv]
// self-checking bench for the clock source unit with a crystal model
// assumes fcm_pkg, the design, checker and crystal model compile first
`timescale 1ns/100ps
module fcm_clock_source_unit_tb;
	import fcm_pkg::*;
	localparam logic [4:0] STEPS [8] = '{5'b01100, 5'b01110, 5'b01111,
		5'b10000, 5'b10010, 5'b10011, 5'b00000, 5'b00100};
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic debug_active = 1'b0;
	logic stop_req = 1'b0;
	logic xtal_run = 1'b1;
	logic ext_ref_in;
	logic [7:0] factory_trim = 8'h00;
	logic factory_fine_trim_bit = 1'b0;
	logic [7:0] reg_rdata;
	logic main_clk, dbg_clk, ff_clk, ff_valid, reference_select_alias_clk, eref_clk, locked;
	fcm_mode_t mode;
	int fail_count = 0;
	int n_compared = 0;
	int seed = 32'ha7782b75;
	logic [7:0] d;
	logic [7:0] r;
	int cs, rs, lp, dbg, h, cm, ci, ce, n0, n2;
	// 25 MHz system clock
	always #20 clk_sys = ~clk_sys;
	fcm_xtal_model xtal (.run(xtal_run), .ref_out(ext_ref_in));
	fcm_clock_source_unit dut (.clk_sys(clk_sys), .nrst(nrst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .debug_active(debug_active),
		.stop_req(stop_req), .ext_ref_in(ext_ref_in),
		.factory_trim(factory_trim), .factory_fine_trim_bit(factory_fine_trim_bit),
		.main_output_clock(main_clk), .debug_local_clock(dbg_clk),
		.fixed_frequency_clock(ff_clk), .fixed_frequency_valid(ff_valid),
		.internal_ref_out_clock(reference_select_alias_clk), .external_ref_out_clock(eref_clk),
		.fll_locked(locked), .mode(mode));
	// one comparison, counted and reported at once
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	// bus cycles: strobes one cycle, read data taken in the next cycle
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	// status follows after synchronisers, so poll with a bound
	task automatic wait_status(input logic [7:0] m, input logic [7:0] v);
		for (int i = 0; i < 400; i++) begin
			rd(ADDR_STAT, d);
			if ((d & m) === v)
				break;
		end
	endtask : wait_status
	// toggles of the main and reference outputs over n cycles
	task automatic count(input int n);
		logic pm, pi, pe;
		cm = 0;
		ci = 0;
		ce = 0;
		repeat (n) begin
			pm = main_clk;
			pi = reference_select_alias_clk;
			pe = eref_clk;
			@(posedge clk_sys);
			#1;
			cm += int'(main_clk !== pm);
			ci += int'(reference_select_alias_clk !== pi);
			ce += int'(eref_clk !== pe);
		end
	endtask : count
	// third toggle gap, so a trim change has surely landed
	task automatic half_period();
		logic p;
		for (int i = 0; i < 3; i++) begin
			h = 0;
			p = reference_select_alias_clk;
			while (reference_select_alias_clk === p && h < 2000) begin
				@(posedge clk_sys);
				#1;
				h++;
			end
		end
	endtask : half_period
	// operating state expected from the control fields
	function automatic logic [15:0] exp_mode(int c, int f, int l, int g);
		if (c == 0)
			return f ? 16'(FCM_ENGAGED_INT) : 16'(FCM_ENGAGED_EXT);
		if (c == 1)
			return (l && !g) ? 16'(FCM_BYPASS_INT_LP) : 16'(FCM_BYPASS_INT);
		return (l && !g) ? 16'(FCM_BYPASS_EXT_LP) : 16'(FCM_BYPASS_EXT);
	endfunction : exp_mode
	initial begin
		{factory_trim, factory_fine_trim_bit} <= 9'($random(seed));
		r = 8'($random(seed));
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		// reset values and trim load
		rd(ADDR_CTRL1, d);
		check(d, 8'h04);
		rd(ADDR_TRIM, d);
		check(d, factory_trim);
		rd(ADDR_STAT, d);
		check(d & 8'hfd, {7'h08, factory_fine_trim_bit});
		#1 check(16'(mode), 16'(FCM_ENGAGED_INT));
		wr(ADDR_CTRL2, r);
		rd(ADDR_CTRL2, d);
		check(d, r & 8'hcd);
		wr(ADDR_CTRL2, 8'h40);
		// external source absent: the old selection must hold
		xtal_run = 1'b0;
		repeat (1700) @(posedge clk_sys);
		wr(ADDR_CTRL1, 8'h80);
		repeat (300) @(posedge clk_sys);
		rd(ADDR_STAT, d);
		check(d & 8'h1c, 8'h10);
		xtal_run = 1'b1;
		wait_status(8'h1c, 8'h08);
		check(d & 8'h1c, 8'h08);
		wr(ADDR_CTRL1, 8'h04);
		wait_status(8'h1c, 8'h10);
		// walk every state but stop; a range write in low power must be dropped
		for (int k = 0; k < 8; k++) begin
			cs = STEPS[k][4:3];
			rs = STEPS[k][2];
			lp = STEPS[k][1];
			dbg = STEPS[k][0];
			@(posedge clk_sys);
			debug_active <= dbg[0];
			wr(ADDR_CTRL2, {2'h1, 2'h0, lp[0], 3'h0});
			wr(ADDR_CTRL1, {cs[1:0], 3'h0, rs[0], 2'h0});
			wait_status(8'h1c, {3'h0, rs[0], cs[1:0], 2'h0});
			check(d & 8'h1c, {3'h0, rs[0], cs[1:0], 2'h0});
			repeat (8) @(posedge clk_sys);
			#1 check(16'(mode), exp_mode(cs, rs, lp, dbg));
			if (k == 1)
				wr(ADDR_STAT, {2'h2, 5'h0, factory_fine_trim_bit});
		end
		// reserved range code ignored, then a real range change
		wr(ADDR_STAT, {2'h3, 5'h0, factory_fine_trim_bit});
		repeat (600) @(posedge clk_sys);
		rd(ADDR_STAT, d);
		check(d[7:6], 2'h0);
		wr(ADDR_STAT, {2'h1, 1'b1, 4'h0, factory_fine_trim_bit});
		wait_status(8'he1, {3'h3, 4'h0, factory_fine_trim_bit});
		check(d & 8'he1, {3'h3, 4'h0, factory_fine_trim_bit});
		#1 check(16'(mode), 16'(FCM_ENGAGED_INT));
		// two reference periods so the fixed clock flag settles
		repeat (3200) @(posedge clk_sys);
		#1 check(16'(ff_valid), 16'h1);
		// stop with and without the stop enables
		for (int k = 0; k < 2; k++) begin
			wr(ADDR_CTRL1, 8'h06 | 8'(k));
			wr(ADDR_CTRL2, 8'h44 | 8'(k));
			@(posedge clk_sys);
			stop_req <= 1'b1;
			repeat (20) @(posedge clk_sys);
			count(2000);
			check({cm == 0, ci > 0, ce > 0}, {1'b1, k[0], k[0]});
			check(16'(mode), 16'(FCM_STOP));
			@(posedge clk_sys);
			stop_req <= 1'b0;
		end
		// trim sets the internal reference half period
		wr(ADDR_STAT, {2'h1, 1'b1, 5'h0});
		for (int t = 0; t < 128; t += 64) begin
			wr(ADDR_TRIM, 8'(t));
			half_period();
			// a half period spans the compare value plus one edge
			check(16'(h), 16'(REFERENCE_SELECT_ALIAS_BASE_HALF_CYC + 1 + 2 * t));
		end
		// bus divider acts at once in internal bypass
		wr(ADDR_CTRL1, 8'h46);
		wait_status(8'h1c, 8'h14);
		wr(ADDR_CTRL2, 8'h00);
		count(8000);
		n0 = cm;
		// main no faster than the fixed clock: flag must drop
		check(16'(ff_valid), 16'h0);
		wr(ADDR_CTRL2, 8'h80);
		count(8000);
		n2 = cm;
		check(16'(n0 + 4 >= 4 * n2 && n0 <= 4 * n2 + 4 && n2 > 1), 16'h1);
		conclude();
	end
	// watchdog well beyond the expected run length
	initial begin
		#(60000 * 40);
		fail_count++;
		conclude();
	end
endmodule : fcm_clock_source_unit_tb
bind fcm_clock_source_unit fcm_clock_source_unit_chk u_chk (
	.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .debug_active(debug_active),
	.main_output_clock(main_output_clock),
	.debug_local_clock(debug_local_clock),
	.fixed_frequency_clock(fixed_frequency_clock),
	.internal_ref_out_clock(internal_ref_out_clock),
	.external_ref_out_clock(external_ref_out_clock),
	.fll_locked(fll_locked), .mode(mode));
